// ==== osa_pkg.sv ====
// package: constants, micro-op codes and state layout of the shift/arith datapath
package osa_pkg;

    // ************************************************************
    // register port offsets
    // ************************************************************
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h1;
    localparam logic [3:0] ADR_ACC  = 4'h2;
    localparam logic [3:0] ADR_UPR  = 4'h3;
    localparam logic [3:0] ADR_OPL  = 4'h4;
    localparam logic [3:0] ADR_SEC  = 4'h5;
    localparam logic [3:0] ADR_THD  = 4'h6;
    localparam logic [3:0] ADR_LOW  = 4'h7;
    localparam logic [3:0] ADR_FLD  = 4'h8;
    localparam logic [3:0] ADR_GRD  = 4'h9;
    localparam logic [3:0] ADR_CNT  = 4'ha;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_MOP_LSB = 0;
    localparam int CTRL_LEN_LSB = 5;
    localparam int CTRL_DIR_BIT = 7;
    localparam int CTRL_SEL_BIT = 8;
    localparam int FLD_SF_LSB   = 0;
    localparam int FLD_DF_LSB   = 4;
    localparam int FLD_ERR_LSB  = 8;

    // ************************************************************
    // constants and reset values
    // ************************************************************
    localparam logic [15:0] K_ONE      = 16'h0001;
    localparam logic [15:0] K_HIDDEN   = 16'h0100;
    localparam logic [3:0]  GR_SCR_CLR = 4'hd;
    localparam logic [3:0]  GR_SCR_SET = 4'hc;
    localparam logic [15:0] TRAP_VEC0  = 16'h0004;
    localparam logic [15:0] TRAP_VEC1  = 16'h0010;
    localparam logic [15:0] TRAP_VEC2  = 16'h0014;
    localparam logic [15:0] TRAP_VEC3  = 16'h0018;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [1:0]  RST_LEN    = 2'h1;
    localparam logic [7:0]  RST_CNT    = 8'h00;

    typedef enum logic [4:0] {
        MOP_NOP   = 5'h00,
        MOP_CLOAD = 5'h01,
        MOP_DEC2  = 5'h02,
        MOP_TRAP  = 5'h03,
        MOP_COUNT = 5'h04,
        MOP_RSETU = 5'h05,
        MOP_RSTEP = 5'h06,
        MOP_LODD  = 5'h07,
        MOP_ASL   = 5'h08,
        MOP_DRRSH = 5'h09,
        MOP_ZOR   = 5'h0a,
        MOP_ZTST  = 5'h0b,
        MOP_NEG1  = 5'h0c,
        MOP_NEG2  = 5'h0d,
        MOP_FPST  = 5'h0e,
        MOP_SXOR  = 5'h0f,
        MOP_EXP   = 5'h10,
        MOP_HID   = 5'h11,
        MOP_CATR  = 5'h12
    } osa_mop_e;

    typedef struct packed {
        logic [15:0][15:0] gr;
        logic [15:0]       acc;
        logic [15:0]       br;
        logic [15:0]       b;
        logic [15:0]       dr;
        logic [15:0]       third_shift_word;
        logic [15:0]       lowest_shift_word;
        logic [15:0]       ba;
        logic [15:0]       rdata;
        logic [7:0]        cnt;
        logic [3:0]        sf;
        logic [3:0]        df;
        logic [1:0]        err;
        logic [1:0]        ph;
        logic [1:0]        len;
        osa_mop_e          mop;
        logic              dc;
        logic              c;
        logic              v;
        logic              z;
        logic              sel;
        logic              dir;
        logic              halt;
        logic              bus_data_in_read;
        logic              busy;
    } osa_state_s;

endpackage

// ==== osa_core.sv ====
// shift/arith micro-op datapath with its register port and pulse sequencer
//
// Overview of operation
// RULE_01 - conditional load puts upper reg, or upper plus/minus operand latch, in acc
// RULE_02 - decrement by two runs A minus B minus one with B constant one
// RULE_03 - second pulse loads acc and address, starts bus read; third pulse halts clock
// RULE_04 - trap vector constant loaded into acc, chosen by current error code
// RULE_05 - shift count stepped at first pulse, up on left path, down on right
// RULE_06 - right setup loads acc, shift carry from bit 15, option carry from bit 0
// RULE_07 - right step loads upper, latch, source with shift carry and acc 15:1
// RULE_08 - odd partner register addressed by forcing source field low bit to one
// RULE_09 - left shift by one adds source register to its copy in operand latch
// RULE_10 - left step sets overflow when upper reg bits 15 and 14 differ
// RULE_11 - second work reg shifted left takes zero at bit 0
// RULE_12 - second work reg shifted right takes zero at bit 15
// RULE_13 - zero flag set only when the ORed result held in acc is zero
// RULE_14 - negate loads one's complement of upper reg; two's is zero minus
// RULE_15 - float store writes acc to upper, latch, scratch 13 if select clear else 12
// RULE_16 - product sign is XOR of the two operand signs
// RULE_17 - exponent extract: acc high byte zero, low byte latch high byte
// RULE_18 - hidden bit: octal 400 added to zero-extended latch low byte
// RULE_19 - four-word right shift, upper reg top, lowest word bottom, top gets carry
// RULE_20 - each microword declares a one, two or three pulse cycle length
// RULE_21 - conditional load recodes: equal pass, 1/0 subtract, 0/1 add
`timescale 1ns/1ps
`default_nettype none

module osa_core
    import osa_pkg::*;
(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [15:0] RDATA_O,
    output logic      [15:0] BUS_ADDR_O,
    output logic             BUS_READ_O,
    output logic             CLOCK_HALT_O,
    output logic             BUSY_O
);

    // ************************************************************
    // decoding helpers
    // ************************************************************
    function automatic logic [3:0] odd_of(input logic [3:0] f);
        odd_of = f | 4'h1; // RULE_08
    endfunction

    function automatic logic [15:0] trap_const(input logic [1:0] e);
        unique case (e)
            2'h0: trap_const = TRAP_VEC0;
            2'h1: trap_const = TRAP_VEC1;
            2'h2: trap_const = TRAP_VEC2;
            2'h3: trap_const = TRAP_VEC3;
        endcase
    endfunction

    osa_state_s q;
    osa_state_s d;
    logic [15:0] src;
    logic [15:0] dst;
    logic        p1;
    logic        p2;
    logic        p3;

    assign src = q.gr[q.sf];
    assign dst = q.gr[q.df];
    // pulses last one enabled clock each; a pulse beyond the declared length never comes
    assign p1 = q.busy && (q.ph == 2'h1);
    assign p2 = q.busy && (q.ph == 2'h2);
    assign p3 = q.busy && (q.ph == 2'h3);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        d = q;
        d.bus_data_in_read = 1'b0;
        d.rdata = RST_WORD;
        if (q.busy)
        begin
            unique case (q.mop)
                MOP_CLOAD:
                begin
                    if (p2)
                    begin
                        unique case ({q.dr[0], q.c}) // RULE_01
                            2'b10: d.acc = q.br - q.b; // RULE_21
                            2'b01: d.acc = q.br + q.b;
                            default: d.acc = q.br;
                        endcase
                    end
                end
                MOP_DEC2:
                begin
                    if (p2)
                    begin
                        d.acc = dst - K_ONE - K_ONE; // RULE_02
                        d.ba = dst - K_ONE - K_ONE; // RULE_03
                        d.bus_data_in_read = 1'b1;
                    end
                    if (p3)
                    begin
                        d.halt = 1'b1; // RULE_03
                    end
                end
                MOP_TRAP:
                begin
                    if (p2)
                    begin
                        d.acc = trap_const(q.err); // RULE_04
                    end
                end
                MOP_COUNT:
                begin
                    if (p1)
                    begin
                        d.cnt = q.dir ? q.cnt + 8'h01 : q.cnt - 8'h01; // RULE_05
                    end
                end
                MOP_RSETU:
                begin
                    if (p2)
                    begin
                        d.acc = src; // RULE_06
                        d.dc = src[15];
                        d.c = src[0];
                    end
                end
                MOP_RSTEP:
                begin
                    if (p3)
                    begin
                        d.br = {q.dc, q.acc[15:1]}; // RULE_07
                        d.b = {q.dc, q.acc[15:1]};
                        d.gr[q.sf] = {q.dc, q.acc[15:1]};
                    end
                end
                MOP_LODD:
                begin
                    if (p2)
                    begin
                        d.br = q.gr[odd_of(q.sf)]; // RULE_08
                    end
                end
                MOP_ASL:
                begin
                    if (p2)
                    begin
                        d.acc = src + q.b; // RULE_09
                        d.dr = {q.dr[14:0], 1'b0}; // RULE_11
                        if (q.br[15] != q.br[14])
                        begin
                            d.v = 1'b1; // RULE_10
                        end
                    end
                end
                MOP_DRRSH:
                begin
                    if (p2)
                    begin
                        d.dr = {1'b0, q.dr[15:1]}; // RULE_12
                    end
                end
                MOP_ZOR:
                begin
                    if (p2)
                    begin
                        d.acc = src | q.br; // RULE_13
                    end
                end
                MOP_ZTST:
                begin
                    if (p1)
                    begin
                        d.z = (q.acc == RST_WORD); // RULE_13
                    end
                end
                MOP_NEG1:
                begin
                    if (p2)
                    begin
                        d.acc = ~q.br; // RULE_14
                    end
                end
                MOP_NEG2:
                begin
                    if (p2)
                    begin
                        d.acc = RST_WORD - q.br; // RULE_14
                    end
                end
                MOP_FPST:
                begin
                    if (p1)
                    begin
                        d.br = q.acc; // RULE_15
                        d.b = q.acc;
                        d.gr[q.sel ? GR_SCR_SET : GR_SCR_CLR] = q.acc;
                    end
                end
                MOP_SXOR:
                begin
                    if (p2)
                    begin
                        d.acc = q.b ^ q.lowest_shift_word; // RULE_16
                    end
                end
                MOP_EXP:
                begin
                    if (p2)
                    begin
                        d.acc = {8'h00, q.b[15:8]}; // RULE_17
                    end
                end
                MOP_HID:
                begin
                    if (p2)
                    begin
                        d.acc = K_HIDDEN + {8'h00, q.b[7:0]}; // RULE_18
                    end
                end
                MOP_CATR:
                begin
                    if (p1)
                    begin
                        d.lowest_shift_word = {q.third_shift_word[0], q.lowest_shift_word[15:1]}; // RULE_19
                        d.third_shift_word = {q.dr[0], q.third_shift_word[15:1]};
                        d.dr = {q.br[0], q.dr[15:1]};
                        d.br = {q.dc, q.acc[15:1]};
                    end
                end
                default:
                begin
                    d.acc = q.acc;
                end
            endcase
            // microword ends after its declared pulse count
            if (q.ph == q.len) // RULE_20
            begin
                d.busy = 1'b0;
                d.ph = 2'h0;
            end
            else
            begin
                d.ph = q.ph + 2'h1;
            end
        end
        if (RD_I)
        begin
            unique case (ADDR_I)
                ADR_CTRL: d.rdata = {7'h00, q.sel, q.dir, q.len, q.mop};
                ADR_STAT: d.rdata = {8'h00, q.busy, q.halt, q.sel, q.dir,
                                     q.z, q.v, q.c, q.dc};
                ADR_ACC:  d.rdata = q.acc;
                ADR_UPR:  d.rdata = q.br;
                ADR_OPL:  d.rdata = q.b;
                ADR_SEC:  d.rdata = q.dr;
                ADR_THD:  d.rdata = q.third_shift_word;
                ADR_LOW:  d.rdata = q.lowest_shift_word;
                ADR_FLD:  d.rdata = {6'h00, q.err, q.df, q.sf};
                ADR_GRD:  d.rdata = src;
                ADR_CNT:  d.rdata = {8'h00, q.cnt};
                default:  d.rdata = RST_WORD;
            endcase
        end
        // software writes override a datapath update in the same cycle
        if (WR_I)
        begin
            unique case (ADDR_I)
                ADR_CTRL:
                begin
                    // a start while busy is dropped so a microword is never cut short
                    if (!q.busy && (WDATA_I[CTRL_LEN_LSB +: 2] != 2'h0))
                    begin
                        d.mop = osa_mop_e'(WDATA_I[CTRL_MOP_LSB +: 5]);
                        d.len = WDATA_I[CTRL_LEN_LSB +: 2]; // RULE_20
                        d.dir = WDATA_I[CTRL_DIR_BIT];
                        d.sel = WDATA_I[CTRL_SEL_BIT];
                        d.busy = 1'b1;
                        d.ph = 2'h1;
                        d.halt = 1'b0;
                    end
                end
                ADR_STAT:
                begin
                    d.dc = WDATA_I[0];
                    d.c = WDATA_I[1];
                    d.v = WDATA_I[2];
                    d.z = WDATA_I[3];
                end
                ADR_ACC: d.acc = WDATA_I;
                ADR_UPR: d.br = WDATA_I;
                ADR_OPL: d.b = WDATA_I;
                ADR_SEC: d.dr = WDATA_I;
                ADR_THD: d.third_shift_word = WDATA_I;
                ADR_LOW: d.lowest_shift_word = WDATA_I;
                ADR_FLD:
                begin
                    d.sf = WDATA_I[FLD_SF_LSB +: 4];
                    d.df = WDATA_I[FLD_DF_LSB +: 4];
                    d.err = WDATA_I[FLD_ERR_LSB +: 2];
                end
                ADR_GRD: d.gr[q.sf] = WDATA_I;
                ADR_CNT: d.cnt = WDATA_I[7:0];
                default: d.cnt = q.cnt;
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            q <= '0;
            q.len <= RST_LEN;
            q.cnt <= RST_CNT;
            q.mop <= MOP_NOP;
        end
        else if (CE_I)
        begin
            q <= d;
        end
    end

    assign RDATA_O = q.rdata;
    assign BUS_ADDR_O = q.ba;
    assign BUS_READ_O = q.bus_data_in_read;
    assign CLOCK_HALT_O = q.halt;
    assign BUSY_O = q.busy;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence at_pulse(logic [1:0] n, osa_mop_e m);
        CE_I && !WR_I && q.busy && (q.ph == n) && (q.mop == m);
    endsequence

    sequence dec_issue;
        at_pulse(2'h2, MOP_DEC2) ##1 CE_I && !WR_I && q.busy && q.ph == 2'h3;
    endsequence

    cond_sub_a: assert property (at_pulse(2'h2, MOP_CLOAD) ##0 (q.dr[0] && !q.c) // RULE_21
        |=> q.acc == 16'($past(q.br) - $past(q.b)))
        else $error("conditional subtract wrong");

    dec_two_a: assert property (at_pulse(2'h2, MOP_DEC2) // RULE_02
        |=> q.acc == 16'($past(dst) - 16'h0002) && BUS_READ_O && BUS_ADDR_O == q.acc)
        else $error("decrement by two wrong");

    halt_seq_a: assert property (dec_issue |=> CLOCK_HALT_O && !BUS_READ_O) // RULE_03
        else $error("clock halt not at third pulse");

    count_step_a: assert property (at_pulse(2'h1, MOP_COUNT) // RULE_05
        |=> q.cnt == 8'($past(q.cnt) + ($past(q.dir) ? 8'h01 : 8'hff)))
        else $error("shift count step wrong");

    rsh_setup_a: assert property (at_pulse(2'h2, MOP_RSETU) // RULE_06
        |=> q.dc == q.acc[15] && q.c == q.acc[0] && q.acc == $past(src))
        else $error("right setup wrong");

    rsh_step_a: assert property (at_pulse(2'h3, MOP_RSTEP) // RULE_07
        |=> q.br == {$past(q.dc), $past(q.acc[15:1])} && q.b == q.br)
        else $error("right step wrong");

    asl_ovf_a: assert property (at_pulse(2'h2, MOP_ASL) ##0 (q.br[15] ^ q.br[14]) // RULE_10
        |=> q.v && q.dr[0] == 1'b0)
        else $error("overflow not set on left step");

    zero_test_a: assert property (at_pulse(2'h1, MOP_ZTST) // RULE_13
        |=> q.z == ($past(q.acc) == 16'h0000))
        else $error("zero flag wrong");

    hidden_bit_a: assert property (at_pulse(2'h2, MOP_HID) // RULE_18
        |=> q.acc == 16'h0100 + {8'h00, $past(q.b[7:0])})
        else $error("hidden bit insert wrong");

    cat_shift_a: assert property (at_pulse(2'h1, MOP_CATR) // RULE_19
        |=> q.lowest_shift_word[15] == $past(q.third_shift_word[0]) && q.dr[15] == $past(q.br[0]) && q.br[15] == $past(q.dc))
        else $error("concatenated shift wrong");

    word_end_a: assert property (CE_I && q.busy && q.ph == q.len // RULE_20
        |=> !BUSY_O)
        else $error("microword overran its length");

endmodule

`default_nettype wire

// ==== osa_host_model.sv ====
// host side model: counts bus reads and freezes the option while data comes in
`timescale 1ns/1ps
`default_nettype none

module osa_host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        read_i,
    output logic             ce_o = 1'b1,
    output logic      [15:0] last_addr_o = 16'h0000,
    output int               reads_o = 0
);
    int   stall = 0;
    logic read_q = 1'b0;

    // ************************************************************
    // bus wait
    // ************************************************************
    // edge detect, since a frozen pulse may stand over several cycles
    always @(posedge clk_i)
    begin
        read_q <= read_i;
        if (rst_i)
        begin
            ce_o    <= 1'b1;
            stall   <= 0;
            reads_o <= 0;
        end
        else if (read_i && !read_q)
        begin
            ce_o        <= 1'b0;
            stall       <= $urandom_range(4, 0);
            reads_o     <= reads_o + 1;
            last_addr_o <= addr_i;
        end
        else if (stall > 0)
            stall <= stall - 1;
        else
            ce_o <= 1'b1;
    end
endmodule

`default_nettype wire

// ==== option_shift_arith_microops_tb.sv ====
// self-checking bench for the shift/arith micro-op datapath
`timescale 1ns/1ps
`default_nettype none

module option_shift_arith_microops_tb;
    import osa_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, bus_addr, last_addr, br, b, dr, third_shift_word, lowest_shift_word, g, a, e;
    logic        ce, bus_read, halt, busy, s, d;
    logic [7:0]  c;
    logic [3:0]  st, r;
    logic [1:0]  err;
    logic [63:0] w;
    int          reads, nrd = 0, fail_count = 0, cmp_count = 0, cycles = 0;
    osa_mop_e    ops[16] = '{MOP_CLOAD, MOP_DEC2, MOP_TRAP, MOP_COUNT, MOP_RSETU,
        MOP_LODD, MOP_ASL, MOP_DRRSH, MOP_ZOR, MOP_NEG1, MOP_NEG2, MOP_FPST,
        MOP_SXOR, MOP_EXP, MOP_HID, MOP_CATR};

    osa_core i_osa_core (
        .CLK_SYS_I   (clk),
        .RST_I       (rst),
        .CE_I        (ce),
        .ADDR_I      (addr),
        .WDATA_I     (wdata),
        .WR_I        (wr),
        .RD_I        (rd),
        .RDATA_O     (rdata),
        .BUS_ADDR_O  (bus_addr),
        .BUS_READ_O  (bus_read),
        .CLOCK_HALT_O(halt),
        .BUSY_O      (busy)
    );

    osa_host_model i_osa_host_model (
        .clk_i      (clk),
        .rst_i      (rst),
        .addr_i     (bus_addr),
        .read_i     (bus_read),
        .ce_o       (ce),
        .last_addr_o(last_addr),
        .reads_o    (reads)
    );

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            finish_test();
        end
    end

    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic finish_test();
        $display("mismatches %0d, compares %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] ex, input logic [3:0] ra);
        cmp_count++;
        if (got !== ex)
        begin
            fail_count++;
            $display("wrong value at %0t: reg %h got %h exp %h", $time, ra, got, ex);
        end
    endtask

    // strobes are lost while the host holds the option frozen
    task automatic sync();
        @(negedge clk);
        while (ce !== 1'b1)
            @(negedge clk);
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [3:0] ra, input logic [15:0] wd);
        sync();
        wr    <= 1'b1;
        addr  <= ra;
        wdata <= wd;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic chk(input logic [3:0] ra, input logic [15:0] ex);
        sync();
        rd   <= 1'b1;
        addr <= ra;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp16(rdata, ex, ra);
        @(negedge clk);
        cmp16(rdata, 16'h0000, ra);
    endtask

    task automatic run(input osa_mop_e m, input logic [3:0] x);
        int k;
        wr_reg(ADR_CTRL, {7'h00, x, m});
        for (k = 0; k < 40; k++)
        begin
            @(negedge clk);
            if (busy === 1'b0 && ce === 1'b1)
                break;
        end
        if (k == 40)
            cmp16({15'h0000, busy}, 16'h0000, ADR_STAT);
    endtask

    task automatic rnd();
        {br, b} = $urandom;
        {dr, third_shift_word} = $urandom;
        {lowest_shift_word, g} = $urandom;
        {a, c} = 24'($urandom);
        {st, r, err} = 10'($urandom);
    endtask

    task automatic load();
        wr_reg(ADR_UPR, br);
        wr_reg(ADR_OPL, b);
        wr_reg(ADR_SEC, dr);
        wr_reg(ADR_THD, third_shift_word);
        wr_reg(ADR_LOW, lowest_shift_word);
        wr_reg(ADR_ACC, a);
        wr_reg(ADR_CNT, {8'h00, c});
        wr_reg(ADR_FLD, {6'h00, err, r, r});
        wr_reg(ADR_GRD, g);
        wr_reg(ADR_STAT, {12'h000, st});
    endtask

    function automatic logic [15:0] exp_acc(input osa_mop_e m);
        case (m)
            MOP_CLOAD: return {dr[0], st[1]} == 2'b10 ? br - b : {dr[0], st[1]} == 2'b01 ? br + b : br;
            MOP_DEC2:  return g - 16'h0002;
            MOP_TRAP:  return err == 2'h0 ? TRAP_VEC0 : err == 2'h1 ? TRAP_VEC1 :
                              err == 2'h2 ? TRAP_VEC2 : TRAP_VEC3;
            MOP_RSETU: return g;
            MOP_ASL:   return g + b;
            MOP_ZOR:   return g | br;
            MOP_NEG1:  return ~br;
            MOP_NEG2:  return 16'h0000 - br;
            MOP_SXOR:  return b ^ lowest_shift_word;
            MOP_EXP:   return {8'h00, b[15:8]};
            MOP_HID:   return 16'h0100 + {8'h00, b[7:0]};
            default:   return a;
        endcase
    endfunction

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        void'($urandom(6));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        chk(ADR_ACC, RST_WORD);
        chk(ADR_CNT, 16'h0000);
        chk(4'hb, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            foreach (ops[j])
            begin
                rnd();
                s = i[0];
                d = i[1];
                if (i < 4 && ops[j] == MOP_CLOAD)
                    {dr[0], st[1]} = 2'(i);
                if (i == 0)
                    {g, br} = 32'h0000_0000;
                if (ops[j] == MOP_CATR)
                    a = br;
                load();
                if (ops[j] == MOP_LODD)
                begin
                    wr_reg(ADR_FLD, {6'h00, err, r, r | 4'h1});
                    wr_reg(ADR_GRD, third_shift_word);
                    wr_reg(ADR_FLD, {6'h00, err, r, r});
                end
                run(ops[j], {s, d, 2'h3});
                chk(ADR_ACC, exp_acc(ops[j]));
                case (ops[j])
                    MOP_DEC2:
                    begin
                        nrd++;
                        cmp16(bus_addr, g - 16'h0002, 4'hf);
                        cmp16(last_addr, g - 16'h0002, 4'hf);
                        cmp16(16'(reads), 16'(nrd), 4'hf);
                        cmp16({15'h0000, halt}, 16'h0001, 4'hf);
                    end
                    MOP_COUNT: chk(ADR_CNT, {8'h00, d ? c + 8'h01 : c - 8'h01});
                    MOP_RSETU:
                    begin
                        chk(ADR_STAT, {10'h000, s, d, st[3:2], g[0], g[15]});
                        run(MOP_RSTEP, 4'h3);
                        e = {g[15], g[15:1]};
                        chk(ADR_UPR, e);
                        chk(ADR_OPL, e);
                        chk(ADR_GRD, e);
                    end
                    MOP_LODD: chk(ADR_UPR, third_shift_word);
                    MOP_ASL:
                    begin
                        chk(ADR_SEC, {dr[14:0], 1'b0});
                        chk(ADR_STAT, {10'h000, s, d, st[3], st[2] | (br[15] ^ br[14]), st[1:0]});
                    end
                    MOP_DRRSH: chk(ADR_SEC, {1'b0, dr[15:1]});
                    MOP_ZOR:
                    begin
                        run(MOP_ZTST, 4'h1);
                        chk(ADR_STAT, {12'h000, (g | br) == 16'h0000, st[2:0]});
                    end
                    MOP_FPST:
                    begin
                        chk(ADR_UPR, a);
                        chk(ADR_OPL, a);
                        wr_reg(ADR_FLD, {12'h000, s ? 4'hc : 4'hd});
                        chk(ADR_GRD, a);
                    end
                    MOP_CATR:
                    begin
                        w = {st[0], br, dr, third_shift_word, lowest_shift_word[15:1]};
                        chk(ADR_UPR, w[63:48]);
                        chk(ADR_SEC, w[47:32]);
                        chk(ADR_THD, w[31:16]);
                        chk(ADR_LOW, w[15:0]);
                    end
                    default: ;
                endcase
            end
        end
        // one-pulse microword must not reach the second-pulse load
        rnd();
        {dr[0], st[1]} = 2'b10;
        load();
        run(MOP_CLOAD, 4'h1);
        chk(ADR_ACC, a);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk(ADR_ACC, RST_WORD);
        finish_test();
    end
endmodule

`default_nettype wire
